// [core/drive_control_status_words.sv]
// Cyclic control word interpreter and main status word builder of the drive.
`timescale 1ns/1ps
`include "drive_control_defines.svh"
// What this block does
// - Switch-on bit set permits pulses; cleared brakes on normal ramp to ready.
// - Bit 1 cleared removes pulses at once and inhibits switching on.
// - Bit 2 cleared brakes on quick-stop ramp, then removes pulses, inhibits.
// - Pulses only while bit 3 set; clearing it cancels pulses.
// - Positioning: bit 4 cleared rejects task, ramps at maximum deceleration.
// - Positioning: bit 5 cleared pauses the current motion task.
// - Rising edge of bit 6 starts a motion task; level ignored.
// - Rising edge of bit 7 acknowledges and clears pending faults.
// - Bits 8 and 9 run first and second jog while set and operation is enabled.
// - Control accepted only while bit 10 set; request shown in status bit 9.
// - Positioning: bit 11 set runs homing, cleared stops it.
// - Auxiliary bit 8 commands travel to a fixed stop.
// - Auxiliary bits 12 to 15 hold master life counter, bit 12 lowest.
// - Speed telegrams: auxiliary bit 4 bypasses the ramp generator.
// - Speed telegrams: auxiliary bit 6 inhibits the speed integrator.
// - Positioning bit 8 selects absolute, else relative targets.
// - Positioning bit 15 selects direct setpoint positioning.
// - Second positioning word bit 14 enables software limit switches.
// - Status bits 0..2 show ready on, ready to operate, operation enabled.
// - Status bit 3 shows fault, bit 7 shows warning.
// - Status bits 4,5 show no coast, no quick stop; bit 6 inhibit.
// - Status bit 8 speed in tolerance, bit 10 comparison value reached.
// - Slave life counter returned in auxiliary status bits 12 to 15.
module drive_control_status_words #(
    parameter int LIFE_W = `LIFE_W
) (
    input wire logic sys_clk, // Drive clock, 20 MHz.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic wordStrobe, // One-cycle pulse: new control words valid.
    input wire logic [15:0] mainControlWord, // Main control word.
    input wire logic [15:0] auxControlWord, // Auxiliary control word.
    input wire logic [15:0] posControlWord, // Positioning control word.
    input wire logic [15:0] posControlWordTwo, // Second positioning control word.
    input wire logic positioningMode, // 1 positioning telegram, 0 speed telegram.
    input wire logic lifeMonitorEnable, // Enables master life sign watch.
    input wire logic faultPresent, // Motion core fault level.
    input wire logic warningPresent, // Motion core warning level.
    input wire logic standstill, // Motion core reports motor at rest.
    input wire logic speedInTolerance, // Speed error within tolerance.
    input wire logic compareReached, // Comparison value reached or exceeded.
    output logic pulseEnable, // Power pulses allowed.
    output logic rampStop, // Brake along the normal ramp.
    output logic quickStop, // Brake along the quick-stop ramp.
    output logic taskReject, // Reject task, maximum deceleration.
    output logic taskPause, // Pause the current task.
    output logic taskStart, // One-cycle pulse: activate a task.
    output logic faultAck, // One-cycle pulse: clear acknowledged faults.
    output logic firstJog, // First jog running.
    output logic secondJog, // Second jog running.
    output logic homing, // Homing sequence running.
    output logic fixedStop, // Travel to fixed stop.
    output logic rampBypass, // Bypass ramp generator.
    output logic integratorInhibit, // Inhibit speed integrator.
    output logic absolutePos, // 1 absolute, 0 relative targets.
    output logic directSetpoint, // Direct setpoint positioning selected.
    output logic softLimits, // Software limit switches active.
    output logic [3:0] masterLife, // Received master life counter.
    output logic lifeSignFault, // Master life counter stalled.
    output logic [15:0] mainStatusWord, // Main status word.
    output logic [15:0] auxStatusWord // Auxiliary status word.
);
    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    // A wider counter would not fit the four-bit field of the auxiliary words.
    if (LIFE_W != `LIFE_MSB - `LIFE_LSB + 1) begin
        $error("LIFE_W must match the life sign field width.");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    drive_control_pkg::core_type cur;
    drive_control_pkg::core_type next_cur;

    function automatic logic rose(input logic [15:0] nw, input logic [15:0] old,
                                  input int b);
        rose = nw[b] & ~old[b];
    endfunction : rose

    logic coastOk;
    logic quickOk;
    logic onReq;
    logic opReq;
    assign coastOk = cur.mainWord[`CW_NO_COAST];
    assign quickOk = cur.mainWord[`CW_NO_QUICK];
    assign onReq = cur.mainWord[`CW_SWITCH_ON];
    assign opReq = cur.mainWord[`CW_ENABLE_OP];

    always_comb begin
        logic accept;
        logic [3:0] oldLife;
        accept = 1'b0;
        oldLife = cur.auxWord[`LIFE_MSB:`LIFE_LSB];
        next_cur = cur;
        next_cur.taskStart = 1'b0;
        next_cur.faultAck = 1'b0;
        accept = wordStrobe & mainControlWord[`CW_REMOTE];
        if (wordStrobe) begin
            next_cur.remote = mainControlWord[`CW_REMOTE];
        end
        if (accept) begin
            next_cur.mainWord = mainControlWord;
            next_cur.auxWord = auxControlWord;
            next_cur.posWord = posControlWord;
            next_cur.posWordTwo = posControlWordTwo;
            next_cur.slaveLife = cur.slaveLife + `ONE_LIFE;
            next_cur.taskStart = rose(mainControlWord, cur.mainWord, `CW_TASK_START);
            next_cur.faultAck = rose(mainControlWord, cur.mainWord, `CW_FAULT_ACK);
        end
        // Acknowledge clears the stall flag, but a stall seen in the same cycle wins.
        if (next_cur.faultAck) begin
            next_cur.lifeFault = 1'b0;
        end
        if (accept && lifeMonitorEnable &&
            auxControlWord[`LIFE_MSB:`LIFE_LSB] == oldLife) begin
            next_cur.lifeFault = 1'b1;
        end
        // A fault stops everything immediately, like a coast stop.
        case (cur.state)
            drive_control_pkg::INHIBITED: begin
                // Inhibit until both stops released and switch-on low.
                if (!onReq && coastOk && quickOk && !faultPresent) begin
                    next_cur.state = drive_control_pkg::READY_ON;
                end
            end
            drive_control_pkg::READY_ON: begin
                if (!coastOk || !quickOk || faultPresent) begin
                    next_cur.state = drive_control_pkg::INHIBITED;
                end else if (onReq) begin
                    next_cur.state = drive_control_pkg::SWITCHED_ON;
                end
            end
            drive_control_pkg::SWITCHED_ON: begin
                if (!coastOk || !quickOk || faultPresent) begin
                    next_cur.state = drive_control_pkg::INHIBITED;
                end else if (!onReq) begin
                    next_cur.state = drive_control_pkg::READY_ON;
                end else if (opReq) begin
                    next_cur.state = drive_control_pkg::OPERATING;
                end
            end
            drive_control_pkg::OPERATING: begin
                if (!coastOk || faultPresent) begin
                    next_cur.state = drive_control_pkg::INHIBITED;
                end else if (!quickOk) begin
                    next_cur.state = drive_control_pkg::QUICK_STOPPING;
                end else if (!onReq) begin
                    next_cur.state = drive_control_pkg::RAMP_STOPPING;
                end else if (!opReq) begin
                    next_cur.state = drive_control_pkg::SWITCHED_ON;
                end
            end
            drive_control_pkg::RAMP_STOPPING: begin
                if (!coastOk || faultPresent || !opReq) begin
                    next_cur.state = drive_control_pkg::INHIBITED;
                end else if (!quickOk) begin
                    next_cur.state = drive_control_pkg::QUICK_STOPPING;
                end else if (standstill) begin
                    // Back to ready once at rest.
                    next_cur.state = drive_control_pkg::READY_ON;
                end
            end
            drive_control_pkg::QUICK_STOPPING: begin
                // Pulses off and inhibit after the quick ramp.
                if (!coastOk || faultPresent || standstill || !opReq) begin
                    next_cur.state = drive_control_pkg::INHIBITED;
                end
            end
            default: begin
                next_cur.state = drive_control_pkg::INHIBITED;
            end
        endcase
        // Main status word; reserved bits zero.
        next_cur.mainStatus = `ZERO_WORD;
        next_cur.mainStatus[`SW_READY_ON] =
            next_cur.state != drive_control_pkg::INHIBITED;
        next_cur.mainStatus[`SW_READY_OP] =
            next_cur.state != drive_control_pkg::INHIBITED &&
            next_cur.state != drive_control_pkg::READY_ON;
        next_cur.mainStatus[`SW_OP_ENABLED] =
            next_cur.state == drive_control_pkg::OPERATING;
        next_cur.mainStatus[`SW_FAULT] = faultPresent | next_cur.lifeFault;
        next_cur.mainStatus[`SW_NO_COAST] = next_cur.mainWord[`CW_NO_COAST];
        next_cur.mainStatus[`SW_NO_QUICK] = next_cur.mainWord[`CW_NO_QUICK];
        next_cur.mainStatus[`SW_INHIBIT] =
            next_cur.state == drive_control_pkg::INHIBITED;
        next_cur.mainStatus[`SW_WARNING] = warningPresent;
        next_cur.mainStatus[`SW_SPEED_TOL] = speedInTolerance;
        next_cur.mainStatus[`SW_CONTROL_REQ] = next_cur.remote;
        next_cur.mainStatus[`SW_COMPARE] = compareReached;
        // Slave life sign and fixed-stop echo.
        next_cur.auxStatus = `ZERO_WORD;
        next_cur.auxStatus[`LIFE_MSB:`LIFE_LSB] = next_cur.slaveLife;
        next_cur.auxStatus[`AW_FIXED_STOP] = next_cur.auxWord[`AW_FIXED_STOP];
        // Pin levels are decoded from the next state and registered with it, so they
        // change on the same edge as the status word and never glitch.
        // A change of positioningMode reaches the mode-gated pins one clock later.
        // Pulses while running or braking.
        next_cur.pulseEnable = next_cur.state == drive_control_pkg::OPERATING ||
            next_cur.state == drive_control_pkg::RAMP_STOPPING ||
            next_cur.state == drive_control_pkg::QUICK_STOPPING;
        next_cur.rampStop = next_cur.state == drive_control_pkg::RAMP_STOPPING;
        next_cur.quickStop = next_cur.state == drive_control_pkg::QUICK_STOPPING;
        next_cur.taskReject = positioningMode & ~next_cur.mainWord[`CW_NO_REJECT];
        next_cur.taskPause = positioningMode & ~next_cur.mainWord[`CW_NO_PAUSE];
        next_cur.firstJog = next_cur.mainWord[`CW_FIRST_JOG] &
            (next_cur.state == drive_control_pkg::OPERATING);
        next_cur.secondJog = next_cur.mainWord[`CW_SECOND_JOG] &
            (next_cur.state == drive_control_pkg::OPERATING);
        next_cur.homing = positioningMode & next_cur.mainWord[`CW_HOMING];
        next_cur.rampBypass = ~positioningMode & next_cur.auxWord[`AW_RAMP_BYPASS];
        next_cur.integratorInhibit = ~positioningMode & next_cur.auxWord[`AW_INT_INHIBIT];
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cur.state <= drive_control_pkg::INHIBITED;
            cur.mainWord <= `ZERO_WORD;
            cur.auxWord <= `ZERO_WORD;
            cur.posWord <= `ZERO_WORD;
            cur.posWordTwo <= `ZERO_WORD;
            cur.remote <= 1'b0;
            cur.taskStart <= 1'b0;
            cur.faultAck <= 1'b0;
            cur.lifeFault <= 1'b0;
            cur.slaveLife <= `ZERO_LIFE;
            cur.mainStatus <= `ZERO_WORD;
            cur.auxStatus <= `ZERO_WORD;
            cur.pulseEnable <= 1'b0;
            cur.rampStop <= 1'b0;
            cur.quickStop <= 1'b0;
            cur.taskReject <= 1'b0;
            cur.taskPause <= 1'b0;
            cur.firstJog <= 1'b0;
            cur.secondJog <= 1'b0;
            cur.homing <= 1'b0;
            cur.rampBypass <= 1'b0;
            cur.integratorInhibit <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    logic running;
    assign running = cur.state == drive_control_pkg::OPERATING;
    // Every pin below is a flip-flop or a slice of one.
    // Pulse and stop levels.
    assign pulseEnable = cur.pulseEnable;
    assign rampStop = cur.rampStop;
    assign quickStop = cur.quickStop;
    assign taskReject = cur.taskReject;
    assign taskPause = cur.taskPause;
    assign taskStart = cur.taskStart;
    assign faultAck = cur.faultAck;
    assign firstJog = cur.firstJog;
    assign secondJog = cur.secondJog;
    assign homing = cur.homing;
    assign fixedStop = cur.auxWord[`AW_FIXED_STOP];
    assign rampBypass = cur.rampBypass;
    assign integratorInhibit = cur.integratorInhibit;
    assign absolutePos = cur.posWord[`PW_ABSOLUTE];
    assign directSetpoint = cur.posWord[`PW_DIRECT];
    assign softLimits = cur.posWordTwo[`PW2_SOFT_LIMIT];
    assign masterLife = cur.auxWord[`LIFE_MSB:`LIFE_LSB];
    assign lifeSignFault = cur.lifeFault;
    assign mainStatusWord = cur.mainStatus;
    assign auxStatusWord = cur.auxStatus;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    coast_removes_pulses_a: assert property (
        running && !coastOk |=> cur.state == drive_control_pkg::INHIBITED)
        else $error("Coast stop did not inhibit.");
    quick_stop_ramp_a: assert property (
        running && coastOk && !quickOk && !faultPresent |=> quickStop ##0 pulseEnable)
        else $error("Quick stop ramp not entered.");
    ramp_stop_a: assert property (
        running && coastOk && quickOk && opReq && !onReq && !faultPresent |=> rampStop)
        else $error("Normal ramp stop not entered.");
    enable_op_a: assert property (
        !opReq |=> !cur.mainStatus[`SW_OP_ENABLED])
        else $error("Operation enabled without enable bit.");
    task_edge_a: assert property (
        taskStart |=> !taskStart)
        else $error("Task start longer than one cycle.");
    task_cause_a: assert property (
        taskStart |-> cur.mainWord[`CW_TASK_START] && !$past(cur.mainWord[`CW_TASK_START]))
        else $error("Task start without rising edge.");
    ack_cause_a: assert property (
        faultAck |-> cur.mainWord[`CW_FAULT_ACK] && !$past(cur.mainWord[`CW_FAULT_ACK]))
        else $error("Fault acknowledge without rising edge.");
    remote_gate_a: assert property (
        wordStrobe && !mainControlWord[`CW_REMOTE] |=> $stable(cur.mainWord))
        else $error("Control word taken without remote bit.");
    status_inhibit_a: assert property (
        mainStatusWord[`SW_INHIBIT] |-> !mainStatusWord[`SW_READY_ON] && !pulseEnable)
        else $error("Inhibit shown with ready or pulses.");
    life_stall_a: assert property (
        wordStrobe && mainControlWord[`CW_REMOTE] && lifeMonitorEnable &&
        auxControlWord[`LIFE_MSB:`LIFE_LSB] == masterLife |=> lifeSignFault)
        else $error("Stalled life counter not flagged.");
    slave_life_a: assert property (
        wordStrobe && mainControlWord[`CW_REMOTE] |=>
        auxStatusWord[`LIFE_MSB:`LIFE_LSB] == $past(cur.slaveLife) + `ONE_LIFE)
        else $error("Slave life counter did not advance.");

    run_reached_c: cover property (
        cur.state == drive_control_pkg::SWITCHED_ON ##1 running);
    ramp_done_c: cover property (rampStop ##1 cur.state == drive_control_pkg::READY_ON);
    quick_done_c: cover property (quickStop ##1 mainStatusWord[`SW_INHIBIT]);
    task_pulse_c: cover property (running && taskStart);
    jog_run_c: cover property (firstJog && secondJog && pulseEnable);
endmodule : drive_control_status_words

// [include/drive_control_defines.svh]
// Bit positions and widths of the cyclic control and status words.
`ifndef DRIVE_CONTROL_DEFINES_SVH
`define DRIVE_CONTROL_DEFINES_SVH
`define WORD_W 16
`define LIFE_W 4
`define LIFE_LSB 12
`define LIFE_MSB 15
`define CW_SWITCH_ON 0
`define CW_NO_COAST 1
`define CW_NO_QUICK 2
`define CW_ENABLE_OP 3
`define CW_NO_REJECT 4
`define CW_NO_PAUSE 5
`define CW_TASK_START 6
`define CW_FAULT_ACK 7
`define CW_FIRST_JOG 8
`define CW_SECOND_JOG 9
`define CW_REMOTE 10
`define CW_HOMING 11
`define AW_RAMP_BYPASS 4
`define AW_INT_INHIBIT 6
`define AW_FIXED_STOP 8
`define PW_ABSOLUTE 8
`define PW_DIRECT 15
`define PW2_SOFT_LIMIT 14
`define SW_READY_ON 0
`define SW_READY_OP 1
`define SW_OP_ENABLED 2
`define SW_FAULT 3
`define SW_NO_COAST 4
`define SW_NO_QUICK 5
`define SW_INHIBIT 6
`define SW_WARNING 7
`define SW_SPEED_TOL 8
`define SW_CONTROL_REQ 9
`define SW_COMPARE 10
`define ZERO_WORD 16'h0000
`define ZERO_LIFE 4'h0
`define ONE_LIFE 4'h1
`endif

// [include/drive_control_pkg.sv]
// Types shared by the control word interpreter.
`include "drive_control_defines.svh"
package drive_control_pkg;
    typedef enum logic [2:0] {
        INHIBITED,
        READY_ON,
        SWITCHED_ON,
        OPERATING,
        RAMP_STOPPING,
        QUICK_STOPPING
    } drive_state_type;

    typedef struct packed {
        drive_state_type state;
        logic [`WORD_W-1:0] mainWord;
        logic [`WORD_W-1:0] auxWord;
        logic [`WORD_W-1:0] posWord;
        logic [`WORD_W-1:0] posWordTwo;
        logic remote;
        logic taskStart;
        logic faultAck;
        logic lifeFault;
        logic [`LIFE_W-1:0] slaveLife;
        logic [`WORD_W-1:0] mainStatus;
        logic [`WORD_W-1:0] auxStatus;
        logic pulseEnable;
        logic rampStop;
        logic quickStop;
        logic taskReject;
        logic taskPause;
        logic firstJog;
        logic secondJog;
        logic homing;
        logic rampBypass;
        logic integratorInhibit;
    } core_type;
endpackage : drive_control_pkg

// [tb/host_model.sv]
// Behavioural fieldbus host that sends the cyclic control words to the drive.
`timescale 1ns/1ps
module host_model (
    input wire logic sys_clk, // Drive clock.
    output logic wordStrobe, // New words valid for one cycle.
    output logic [15:0] mainControlWord, // Main control word.
    output logic [15:0] auxControlWord, // Auxiliary control word.
    output logic [15:0] posControlWord, // Positioning control word.
    output logic [15:0] posControlWordTwo // Second positioning control word.
);
    logic [3:0] life;
    initial begin
        wordStrobe = 1'b0;
        mainControlWord = 16'h0000;
        auxControlWord = 16'h0000;
        posControlWord = 16'h0000;
        posControlWordTwo = 16'h0000;
        life = 4'h0;
    end
    // Edges and control bit come from the caller's words.
    // Life counter advances on each send unless told to stall.
    task automatic send(input logic [15:0] m, a, p, q, input logic st);
        @(posedge sys_clk);
        if (!st) life = life + 4'h1;
        wordStrobe <= 1'b1;
        mainControlWord <= m;
        auxControlWord <= {life, a[11:0]};
        posControlWord <= p;
        posControlWordTwo <= q;
        @(posedge sys_clk);
        // Stale words are inverted so that nothing relies on them outside the strobe.
        wordStrobe <= 1'b0;
        mainControlWord <= ~m;
        auxControlWord <= ~{life, a[11:0]};
        posControlWord <= ~p;
        posControlWordTwo <= ~q;
    endtask : send
endmodule : host_model

// [tb/tb_top.sv]
// Self-checking testbench of the control word interpreter.
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0;
    logic resetn, positioningMode, lifeMonitorEnable, faultPresent;
    logic warningPresent, standstill, speedInTolerance, compareReached, wordStrobe;
    logic [15:0] mainControlWord, auxControlWord, posControlWord, posControlWordTwo;
    logic pulseEnable, rampStop, quickStop, taskReject, taskPause, taskStart, faultAck;
    logic firstJog, secondJog, homing, fixedStop, rampBypass, integratorInhibit;
    logic absolutePos, directSetpoint, softLimits, lifeSignFault;
    logic [3:0] masterLife;
    logic [15:0] mainStatusWord, auxStatusWord, lastAux;
    int nMismatch = 0;
    int comparisons = 0;
    int starts = 0;
    int acks = 0;
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (taskStart === 1'b1) starts <= starts + 1;
        if (faultAck === 1'b1) acks <= acks + 1;
    end
    host_model host_model_inst (.sys_clk, .wordStrobe, .mainControlWord, .auxControlWord,
        .posControlWord, .posControlWordTwo);
    drive_control_status_words drive_control_status_words_inst (.sys_clk, .resetn,
        .wordStrobe, .mainControlWord, .auxControlWord, .posControlWord, .posControlWordTwo,
        .positioningMode, .lifeMonitorEnable, .faultPresent, .warningPresent, .standstill,
        .speedInTolerance, .compareReached, .pulseEnable, .rampStop, .quickStop, .taskReject,
        .taskPause, .taskStart, .faultAck, .firstJog, .secondJog, .homing, .fixedStop,
        .rampBypass, .integratorInhibit, .absolutePos, .directSetpoint, .softLimits,
        .masterLife, .lifeSignFault, .mainStatusWord, .auxStatusWord);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            nMismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic stop_test;
        if (nMismatch == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // Three edges after the latch edge inside send cover the state update behind it.
    task automatic go(input logic [15:0] m, input logic [15:0] a = 16'h0000,
                      input logic [15:0] p = 16'h0000, input logic [15:0] q = 16'h0000,
                      input logic st = 1'b0);
        host_model_inst.send(m, a, p, q, st);
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : go
    task automatic wait3;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : wait3
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        resetn = 1'b0;
        positioningMode = 1'b1;
        lifeMonitorEnable = 1'b0;
        faultPresent = 1'b0;
        warningPresent = 1'b0;
        standstill = 1'b0;
        speedInTolerance = 1'b0;
        compareReached = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk(mainStatusWord, 16'h0000);
        chk(taskReject, 1'b0);
        @(posedge sys_clk) resetn <= 1'b1;
        wait3;
        chk(mainStatusWord, 16'h0040);
        chk(taskReject, 1'b1);
        go(16'h0406);
        chk(mainStatusWord, 16'h0231);
        chk(pulseEnable, 1'b0);
        go(16'h0407);
        chk(mainStatusWord, 16'h0233);
        go(16'h040f);
        chk(mainStatusWord, 16'h0237);
        chk({pulseEnable, taskReject, taskPause}, 3'b111);
        go(16'h043f);
        chk({taskReject, taskPause}, 2'b00);
        go(16'h047f);
        chk(starts, 1);
        go(16'h047f);
        chk(starts, 1);
        go(16'h0f3f, 16'h0150, 16'h8100, 16'h4000);
        chk({firstJog, secondJog, homing, fixedStop, absolutePos, directSetpoint,
             softLimits, rampBypass, integratorInhibit}, 9'h1fc);
        chk(auxStatusWord & 16'h0fff, 16'h0100);
        lastAux = auxStatusWord;
        @(posedge sys_clk) positioningMode <= 1'b0;
        wait3;
        chk({rampBypass, integratorInhibit, homing}, 3'b110);
        @(posedge sys_clk) positioningMode <= 1'b1;
        warningPresent <= 1'b1;
        speedInTolerance <= 1'b1;
        compareReached <= 1'b1;
        go(16'h0000);
        chk(mainStatusWord, 16'h05b7);
        chk(pulseEnable, 1'b1);
        chk(auxStatusWord[15:12], lastAux[15:12]);
        @(posedge sys_clk) warningPresent <= 1'b0;
        speedInTolerance <= 1'b0;
        compareReached <= 1'b0;
        go(16'h040e);
        chk({rampStop, pulseEnable}, 2'b11);
        chk(auxStatusWord[15:12], 4'(lastAux[15:12] + 4'h1));
        @(posedge sys_clk) standstill <= 1'b1;
        wait3;
        chk({rampStop, pulseEnable}, 2'b00);
        chk(mainStatusWord, 16'h0231);
        @(posedge sys_clk) standstill <= 1'b0;
        go(16'h0407);
        go(16'h040f);
        go(16'h040b);
        chk(quickStop, 1'b1);
        @(posedge sys_clk) standstill <= 1'b1;
        wait3;
        chk({quickStop, pulseEnable, mainStatusWord[6]}, 3'b001);
        @(posedge sys_clk) standstill <= 1'b0;
        go(16'h0406);
        go(16'h0407);
        go(16'h040f);
        go(16'h040d);
        chk({pulseEnable, mainStatusWord[6], mainStatusWord[4]}, 3'b010);
        go(16'h0406);
        go(16'h0407);
        go(16'h040f);
        @(posedge sys_clk) faultPresent <= 1'b1;
        wait3;
        chk({pulseEnable, mainStatusWord[3], mainStatusWord[6]}, 3'b011);
        @(posedge sys_clk) faultPresent <= 1'b0;
        go(16'h0406);
        go(16'h0407);
        go(16'h040f);
        go(16'h0407);
        chk(pulseEnable, 1'b0);
        @(posedge sys_clk) lifeMonitorEnable <= 1'b1;
        go(16'h0406);
        chk(lifeSignFault, 1'b0);
        go(16'h0406, 16'h0000, 16'h0000, 16'h0000, 1'b1);
        chk(lifeSignFault, 1'b1);
        chk(masterLife, host_model_inst.life);
        go(16'h0486);
        chk({acks[3:0], lifeSignFault}, 5'h02);
        stop_test;
    end
    // A full run needs under two hundred cycles, so this bound only trips on a hang.
    initial begin
        #1000000;
        nMismatch++;
        stop_test;
    end
endmodule : tb_top
